// ==== xra_align.sv ====
`timescale 1ns/10ps
module xra_align import xra_pkg::*; #(
  parameter logic [TMR_W-1:0] CALLING_ALIGN_TIMER = CALLING_ALIGN_TIMER_CYC,
  parameter logic [TMR_W-1:0] CALLED_ALIGN_TIMER = CALLED_ALIGN_TIMER_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] rate_sel_in,
  input wire logic called_in,
  input wire logic chan_known_in,
  input wire logic connect_in,
  input wire logic connect_ack_in,
  input wire logic net_release_in,
  input wire logic frame_sync_in,
  input wire logic info_pending_in,
  input wire logic c_scan_in,
  input wire logic t_lead_in,
  input wire logic c_lead_in,
  input wire logic rx_valid_in,
  input wire xra_bit_t rx_bit_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output xra_bit_t tx_bit_out,
  output logic r_lead_out,
  output logic i_lead_out,
  output logic through_out,
  output logic ready_for_data_out,
  output logic clear_ind_out,
  output logic release_req_out,
  output logic busy_out
);

  xra_regs_t r;
  xra_regs_t n;
  logic tick;
  logic running;
  logic expire;
  logic buf_ready;
  logic [TMR_W-1:0] limit;

  // ----------------------------------------------------------------
  // Bit-rate divider and supervision timer terms
  // ----------------------------------------------------------------
  assign running = (r.st != ST_IDLE) && (r.st != ST_CLEAR);
  assign tick = running && (r.div == DIV_RST);
  assign limit = r.called ? CALLED_ALIGN_TIMER : CALLING_ALIGN_TIMER;
  assign expire = (r.st == ST_SEARCH) && (r.tmr == limit - TMR_W'(1));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.release_req = 1'b0;
    n.div = running ? (tick ? xra_rate_div(r.rate) - DIV_W'(1) : r.div - DIV_W'(1))
                    : DIV_RST;
    if (r.tx_pend && buf_ready) begin
      n.tx_pend = 1'b0;
    end
    if (tick && (!r.tx_pend || buf_ready)) begin
      n.tx_pend = 1'b1;
      // Status from C-lead only once through
      n.tx_word = r.through ? xra_bit_t'{data: t_lead_in, status: c_lead_in}
                            : xra_bit_t'{data: MARK, status: STAT_OFF};
    end
    if (r.through) begin
      if (rx_valid_in) begin
        // Any data/status pair is passed, none flagged as error
        n.r_lead = rx_bit_in.data;
        n.i_lead = rx_bit_in.status;
        // Ready flag is sticky, (1, OFF) ignored
        if (rx_bit_in.data == MARK && rx_bit_in.status == STAT_ON) begin
          n.rfd = 1'b1;
        end
      end
    end else begin
      n.r_lead = MARK;
      n.i_lead = STAT_OFF;
    end
    unique case (r.st)
      ST_IDLE: begin
        if (xra_rate_ok(rate_sel_in)) begin
          if (!called_in && chan_known_in) begin
            n.st = ST_CHAN;
            n.called = 1'b0;
            n.rate = rate_sel_in;
          end else if (called_in && connect_ack_in) begin
            // Frames, search and timer at once
            n.st = ST_SEARCH;
            n.called = 1'b1;
            n.rate = rate_sel_in;
            n.tmr = TMR_RST;
          end
        end
      end
      ST_CHAN: begin
        if (connect_in) begin
          n.st = ST_SEARCH;
          n.tmr = TMR_RST;
        end
      end
      ST_SEARCH: begin
        n.tmr = r.tmr + TMR_W'(1);
        if (frame_sync_in) begin
          n.st = ST_DELIVER;
          n.tmr = r.tmr;
        end else if (expire) begin
          n.st = ST_CLEAR;
          n.release_req = 1'b1;
          n.clear_ind = 1'b1;
        end
      end
      ST_DELIVER: begin
        if (!info_pending_in) begin
          n.st = ST_SCAN;
        end
      end
      ST_SCAN: begin
        // Switch just ahead of C sampling
        if (c_scan_in) begin
          n.st = ST_DATA;
          n.through = 1'b1;
        end
      end
      ST_DATA: begin
      end
      ST_CLEAR: begin
      end
    endcase
    if (net_release_in && r.st != ST_IDLE) begin
      n.st = ST_IDLE;
      n.through = 1'b0;
      n.rfd = 1'b0;
      n.clear_ind = 1'b0;
      n.tx_pend = 1'b0;
      n.r_lead = MARK;
      n.i_lead = STAT_OFF;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '{st: ST_IDLE, called: 1'b0, rate: RATE_600, tmr: TMR_RST, div: DIV_RST,
             tx_pend: 1'b0, tx_word: '{data: MARK, status: STAT_OFF}, through: 1'b0,
             rfd: 1'b0, clear_ind: 1'b0, release_req: 1'b0, r_lead: MARK,
             i_lead: STAT_OFF};
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Transmit buffer toward the channel
  // ----------------------------------------------------------------
  xra_buf2 #(
    .W($bits(xra_bit_t))
  ) u_txbuf (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(r.tx_pend),
    .in_ready_out(buf_ready),
    .in_data_in(r.tx_word),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in),
    .out_data_out(tx_bit_out)
  );

  assign r_lead_out = r.r_lead;
  assign i_lead_out = r.i_lead;
  assign through_out = r.through;
  assign ready_for_data_out = r.rfd;
  assign clear_ind_out = r.clear_ind;
  assign release_req_out = r.release_req;
  assign busy_out = running;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_sync_found;
    r.st == ST_SEARCH && frame_sync_in && !net_release_in;
  endsequence

  sequence s_drained;
    r.st == ST_DELIVER && !info_pending_in && !net_release_in;
  endsequence

  a_idle_frame_bits: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (tick && !r.through && (!r.tx_pend || buf_ready))
      |=> r.tx_word.data == MARK && r.tx_word.status == STAT_OFF)
    else $error("idle frame bits wrong");

  a_connect_starts: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.st == ST_CHAN && connect_in && !net_release_in)
      |=> r.st == ST_SEARCH && r.tmr == TMR_RST)
    else $error("connect did not start search and timer");

  a_sync_to_through: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_sync_found ##1 s_drained ##1 (c_scan_in && !net_release_in) |=> r.through)
    else $error("sync path did not switch through");

  a_timer_stops: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_sync_found |=> r.st == ST_DELIVER && $stable(r.tmr))
    else $error("timer kept running after sync");

  a_no_early_map: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !r.through |-> r.r_lead == MARK && r.i_lead == STAT_OFF)
    else $error("leads mapped before switch-through");

  a_switch_on_scan: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.st == ST_SCAN && !c_scan_in) |=> !r.through)
    else $error("switched without scan strobe");

  a_expiry_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (expire && !frame_sync_in && !net_release_in)
      |=> release_req_out && clear_ind_out ##1 !release_req_out)
    else $error("timer expiry did not clear");

  a_map_rx_bits: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.through && rx_valid_in && !net_release_in)
      |=> r.r_lead == $past(rx_bit_in.data) && r.i_lead == $past(rx_bit_in.status))
    else $error("received bits not mapped to leads");

  a_rfd_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.rfd && !net_release_in) |=> r.rfd)
    else $error("ready flag dropped");

  a_called_start: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.st == ST_IDLE && called_in && connect_ack_in && xra_rate_ok(rate_sel_in))
      |=> r.st == ST_SEARCH && r.called && r.tmr == TMR_RST)
    else $error("connect ack did not start called search");

  a_rate_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.st == ST_IDLE && !xra_rate_ok(rate_sel_in)) |=> r.st == ST_IDLE)
    else $error("started at a rate without status");

  a_timer_bound: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    r.st == ST_SEARCH |-> r.tmr < limit)
    else $error("timer passed its limit");

  // ----------------------------------------------------------------
  // Step checks on switch-through, timer, clear, ready flag, start and the transmit path
  // ----------------------------------------------------------------
  sequence s_scan_taken;
    r.st == ST_SCAN && c_scan_in && !net_release_in;
  endsequence

  a_scan_switches: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_scan_taken |=> r.through && r.st == ST_DATA)
    else $error("scan strobe did not switch through");

  a_deliver_waits: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.st == ST_DELIVER && info_pending_in && !net_release_in)
      |=> r.st == ST_DELIVER && !r.through)
    else $error("switched while info still pending");

  a_timer_counts: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.st == ST_SEARCH && !frame_sync_in && !expire && !net_release_in)
      |=> r.st == ST_SEARCH && r.tmr == $past(r.tmr) + TMR_W'(1))
    else $error("supervision timer did not advance");

  a_clear_held: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.clear_ind && !net_release_in) |=> r.clear_ind && !running)
    else $error("clear indication dropped");

  a_tx_follows_leads: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (tick && r.through && (!r.tx_pend || buf_ready))
      |=> r.tx_word.data == $past(t_lead_in) && r.tx_word.status == $past(c_lead_in))
    else $error("sent word does not follow T and C");

  a_rfd_on_ready: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.through && rx_valid_in && rx_bit_in.data == MARK && rx_bit_in.status == STAT_ON
      && !net_release_in) |=> r.rfd)
    else $error("ready condition not flagged");

  a_full_tick_skip: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (tick && r.tx_pend && !buf_ready && !net_release_in)
      |=> r.tx_pend && $stable(r.tx_word))
    else $error("held word overwritten on full buffer");

  a_chan_starts: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (r.st == ST_IDLE && !called_in && chan_known_in && xra_rate_ok(rate_sel_in))
      |=> r.st == ST_CHAN && !r.called && busy_out)
    else $error("channel message did not start sending");

endmodule

// ==== xra_pkg.sv ====
package xra_pkg;

  // ----------------------------------------------------------------
  // Clock and counter widths
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int TMR_W = 32;
  localparam int DIV_W = 17;

  // ----------------------------------------------------------------
  // Supervision timer defaults, in ms and in clock cycles
  // ----------------------------------------------------------------
  localparam int CALLING_ALIGN_TIMER_MS = 1000;
  localparam int CALLED_ALIGN_TIMER_MS = 1000;
  localparam logic [TMR_W-1:0] CALLING_ALIGN_TIMER_CYC =
    TMR_W'(CALLING_ALIGN_TIMER_MS * (CLK_HZ / 1000));
  localparam logic [TMR_W-1:0] CALLED_ALIGN_TIMER_CYC =
    TMR_W'(CALLED_ALIGN_TIMER_MS * (CLK_HZ / 1000));

  // ----------------------------------------------------------------
  // User rate codes; codes above RATE_48000 carry no status
  // ----------------------------------------------------------------
  localparam logic [3:0] RATE_600 = 4'h0;
  localparam logic [3:0] RATE_1200 = 4'h1;
  localparam logic [3:0] RATE_2400 = 4'h2;
  localparam logic [3:0] RATE_4800 = 4'h3;
  localparam logic [3:0] RATE_7200 = 4'h4;
  localparam logic [3:0] RATE_9600 = 4'h5;
  localparam logic [3:0] RATE_14400 = 4'h6;
  localparam logic [3:0] RATE_19200 = 4'h7;
  localparam logic [3:0] RATE_48000 = 4'h8;

  // ----------------------------------------------------------------
  // Lead and status levels, reset values
  // ----------------------------------------------------------------
  localparam logic STAT_ON = 1'b1;
  localparam logic STAT_OFF = 1'b0;
  localparam logic MARK = 1'b1;
  localparam logic [DIV_W-1:0] DIV_RST = 17'h00000;
  localparam logic [TMR_W-1:0] TMR_RST = 32'h00000000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHAN,
    ST_SEARCH,
    ST_DELIVER,
    ST_SCAN,
    ST_DATA,
    ST_CLEAR
  } xra_state_t;

  typedef struct packed {
    logic data;
    logic status;
  } xra_bit_t;

  typedef struct packed {
    xra_state_t st;
    logic called;
    logic [3:0] rate;
    logic [TMR_W-1:0] tmr;
    logic [DIV_W-1:0] div;
    logic tx_pend;
    xra_bit_t tx_word;
    logic through;
    logic rfd;
    logic clear_ind;
    logic release_req;
    logic r_lead;
    logic i_lead;
  } xra_regs_t;

  function automatic logic xra_rate_ok(input logic [3:0] rate);
    return rate <= RATE_48000;
  endfunction

  // Clock cycles per user bit
  function automatic logic [DIV_W-1:0] xra_rate_div(input logic [3:0] rate);
    case (rate)
      RATE_600: return DIV_W'(CLK_HZ / 600);
      RATE_1200: return DIV_W'(CLK_HZ / 1200);
      RATE_2400: return DIV_W'(CLK_HZ / 2400);
      RATE_4800: return DIV_W'(CLK_HZ / 4800);
      RATE_7200: return DIV_W'(CLK_HZ / 7200);
      RATE_9600: return DIV_W'(CLK_HZ / 9600);
      RATE_14400: return DIV_W'(CLK_HZ / 14400);
      RATE_19200: return DIV_W'(CLK_HZ / 19200);
      RATE_48000: return DIV_W'(CLK_HZ / 48000);
      default: return DIV_W'(CLK_HZ / 48000);
    endcase
  endfunction

endpackage

// ==== xra_buf2.sv ====
`timescale 1ns/10ps
module xra_buf2 import xra_pkg::*; #(
  parameter int W = 2
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  typedef struct packed {
    logic [1:0] cnt;
    logic [W-1:0] e1;
    logic [W-1:0] e0;
  } xra_buf_regs_t;

  xra_buf_regs_t r;
  xra_buf_regs_t n;
  logic push;
  logic pop;

  assign in_ready_out = (r.cnt != 2'h2);
  assign out_valid_out = (r.cnt != 2'h0);
  assign out_data_out = r.e0;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    n = r;
    unique case ({push, pop})
      2'b10: begin
        if (r.cnt == 2'h0) begin
          n.e0 = in_data_in;
        end else begin
          n.e1 = in_data_in;
        end
        n.cnt = r.cnt + 2'h1;
      end
      2'b01: begin
        n.e0 = r.e1;
        n.cnt = r.cnt - 2'h1;
      end
      2'b11: begin
        n.e0 = (r.cnt == 2'h1) ? in_data_in : r.e1;
        if (r.cnt == 2'h2) begin
          n.e1 = in_data_in;
        end
      end
      2'b00: begin
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  a_buf_no_overfill: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    r.cnt <= 2'h2) else $error("buffer count above two");

endmodule

// ==== xra_far_end.sv ====
`timescale 1ns/10ps
module xra_far_end import xra_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic stall_in,
  input wire logic tx_valid_in,
  input wire xra_bit_t tx_bit_in,
  output logic tx_ready_out,
  input wire logic send_in,
  input wire xra_bit_t send_bit_in,
  output logic rx_valid_out,
  output xra_bit_t rx_bit_out,
  output logic [15:0] word_cnt_out,
  output xra_bit_t last_word_out
);
  // ----------------------------------------------------------------
  // Channel receive side
  // ----------------------------------------------------------------
  assign tx_ready_out = !stall_in;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_cnt_out <= 16'h0000;
      last_word_out <= 2'h0;
    end else if (tx_valid_in && tx_ready_out) begin
      word_cnt_out <= word_cnt_out + 16'h0001;
      last_word_out <= tx_bit_in;
    end
  end

  // ----------------------------------------------------------------
  // Channel send side
  // ----------------------------------------------------------------
  // Remote condition sent
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_valid_out <= 1'b0;
      rx_bit_out <= 2'h0;
    end else if (send_in) begin
      rx_valid_out <= 1'b1;
      rx_bit_out <= send_bit_in;
    end else begin
      // Stale bits toggle so they never pass for a held value
      rx_valid_out <= 1'b0;
      rx_bit_out <= xra_bit_t'(~rx_bit_out);
    end
  end
endmodule

// ==== x21_switched_ready_for_data_align_tb.sv ====
`timescale 1ns/10ps
module x21_switched_ready_for_data_align_tb import xra_pkg::*;;
  localparam int T_CALLING = 50;
  localparam int T_CALLED = 40;
  localparam int BIT_CYC = CLK_HZ / 48000;
  logic sys_clk_in, rst_n_in, called, chan, conn, ack, rel, sync, pend, scan;
  logic t_lead, c_lead, stall, far_send, rx_valid, tx_ready, tx_valid;
  logic r_lead, i_lead, through, rfd, clr, rreq, busy;
  logic [3:0] rate;
  logic [15:0] word_cnt;
  xra_bit_t far_bit, rx_bit, tx_bit, last_word;
  int failures = 0;
  int tests_run = 0;

  xra_align #(
    .CALLING_ALIGN_TIMER(TMR_W'(T_CALLING)),
    .CALLED_ALIGN_TIMER(TMR_W'(T_CALLED))
  ) u_xra_align (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .rate_sel_in(rate),
    .called_in(called), .chan_known_in(chan), .connect_in(conn),
    .connect_ack_in(ack), .net_release_in(rel), .frame_sync_in(sync),
    .info_pending_in(pend), .c_scan_in(scan), .t_lead_in(t_lead),
    .c_lead_in(c_lead), .rx_valid_in(rx_valid), .rx_bit_in(rx_bit),
    .tx_ready_in(tx_ready), .tx_valid_out(tx_valid), .tx_bit_out(tx_bit),
    .r_lead_out(r_lead), .i_lead_out(i_lead), .through_out(through),
    .ready_for_data_out(rfd), .clear_ind_out(clr), .release_req_out(rreq),
    .busy_out(busy)
  );

  xra_far_end u_xra_far_end (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .stall_in(stall),
    .tx_valid_in(tx_valid), .tx_bit_in(tx_bit), .tx_ready_out(tx_ready),
    .send_in(far_send), .send_bit_in(far_bit), .rx_valid_out(rx_valid),
    .rx_bit_out(rx_bit), .word_cnt_out(word_cnt), .last_word_out(last_word)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk_in);
    case (k)
      0: chan <= 1'b1;
      1: conn <= 1'b1;
      2: ack <= 1'b1;
      4: rel <= 1'b1;
      default: scan <= 1'b1;
    endcase
    @(posedge sys_clk_in);
    {chan, conn, ack, rel, scan} <= 5'h00;
    @(negedge sys_clk_in);
  endtask

  task automatic send(input xra_bit_t b);
    @(posedge sys_clk_in);
    far_send <= 1'b1;
    far_bit <= b;
    @(posedge sys_clk_in);
    far_send <= 1'b0;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask

  task automatic start(input logic side);
    @(posedge sys_clk_in);
    called <= side;
    c_lead <= 1'b1;
    t_lead <= 1'b0;
    pulse(side ? 0 : 2);
    check("wrong side start", busy, 1'b0);
    pulse(side ? 2 : 0);
    check("busy", busy, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("reset r", r_lead, MARK);
    check("reset i", i_lead, STAT_OFF);
    check("reset through", through, 1'b0);
    check("reset busy", busy, 1'b0);
    check("reset valid", tx_valid, 1'b0);
    check("reset clear", clr, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_path(input logic side);
    logic [15:0] n;
    int k;
    // Sync stands from the start so the called side never reaches its timer
    @(posedge sys_clk_in);
    sync <= 1'b1;
    pend <= 1'b1;
    start(side);
    repeat (10) @(negedge sys_clk_in);
    check("idle word", last_word, 2'h2);
    // Start the stall just after an accepted word, far from the next bit tick
    n = word_cnt;
    k = 0;
    while (word_cnt == n && k < 2 * BIT_CYC) begin
      @(negedge sys_clk_in);
      k++;
    end
    check("word before stall", 32'(word_cnt != n), 32'h1);
    if (word_cnt == n) final_report();
    @(posedge sys_clk_in);
    stall <= 1'b1;
    @(negedge sys_clk_in);
    n = word_cnt;
    repeat (4 * BIT_CYC) @(negedge sys_clk_in);
    check("held valid", tx_valid, 1'b1);
    check("stalled count", word_cnt, n);
    @(posedge sys_clk_in);
    stall <= 1'b0;
    repeat (10) @(negedge sys_clk_in);
    // Two buffered words plus the one waiting in front of the buffer
    check("drained count", word_cnt, n + 16'h0003);
    if (!side) pulse(1);
    pulse(5);
    check("early switch", through, 1'b0);
    @(posedge sys_clk_in);
    pend <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    send(2'h1);
    check("i before switch", i_lead, STAT_OFF);
    check("r before switch", r_lead, MARK);
    pulse(5);
    check("through", through, 1'b1);
    send(2'h1);
    check("r mapped", r_lead, 1'b0);
    check("i mapped", i_lead, STAT_ON);
    send(2'h3);
    check("ready", rfd, 1'b1);
    send(2'h2);
    check("ready kept", rfd, 1'b1);
    check("i off", i_lead, STAT_OFF);
    check("still through", through, 1'b1);
    repeat (3 * BIT_CYC) @(negedge sys_clk_in);
    check("mapped word", last_word, 2'h1);
    // Terminal clear request: C drops and must reach the far end before release
    @(posedge sys_clk_in);
    c_lead <= 1'b0;
    repeat (3 * BIT_CYC) @(negedge sys_clk_in);
    check("clear request word", last_word, 2'h0);
    @(posedge sys_clk_in);
    sync <= 1'b0;
    pulse(4);
    check("released", busy, 1'b0);
    check("ready cleared", rfd, 1'b0);
    $display("test path side %0d done", side);
  endtask

  task automatic t_timeout(input logic side);
    int n;
    int lim;
    lim = side ? T_CALLED : T_CALLING;
    start(side);
    if (!side) begin
      repeat (100) @(negedge sys_clk_in);
      check("no early clear", clr, 1'b0);
      pulse(1);
    end
    n = 0;
    while (rreq !== 1'b1 && n < 300) begin
      @(negedge sys_clk_in);
      n++;
    end
    check("expiry window", 32'(n >= lim && n <= lim + 3), 32'h1);
    if (rreq !== 1'b1) final_report();
    check("clear ind", clr, 1'b1);
    @(negedge sys_clk_in);
    check("release pulse", rreq, 1'b0);
    check("busy after expiry", busy, 1'b0);
    pulse(4);
    check("clear dropped", clr, 1'b0);
    $display("test timeout side %0d done", side);
  endtask

  task automatic t_rates;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk_in);
      rate <= 4'(i);
      called <= 1'b0;
      pulse(0);
      check("rate start", busy, 32'(i <= 8));
      pulse(4);
    end
    @(posedge sys_clk_in);
    rate <= RATE_48000;
    $display("test rates done");
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    repeat (90000) @(posedge sys_clk_in);
    $display("watchdog expired");
    failures++;
    final_report();
  end

  initial begin
    rst_n_in = 1'b0;
    {called, chan, conn, ack, rel, sync, pend, scan} = 8'h00;
    {t_lead, c_lead, stall, far_send} = 4'h0;
    far_bit = 2'h0;
    rate = RATE_48000;
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(negedge sys_clk_in);
    t_reset();
    t_rates();
    t_path(1'b0);
    t_path(1'b1);
    t_timeout(1'b0);
    t_timeout(1'b1);
    final_report();
  end
endmodule
